// File: include/gpe_pkg.sv
// constants and carrier types for the general purpose event status block
package gpe_pkg;

    localparam int unsigned NUM_PORTS      = 15;
    localparam int unsigned ADDR_W         = 12;
    localparam int unsigned DATA_W         = 32;

    // register byte addresses
    localparam logic [11:0] CONTROL_OFFSET = 12'h450;
    localparam logic [11:0] STATUS_OFFSET  = 12'h454;
    localparam logic [11:0] PIN_OFFSET     = 12'h458;

    // general_event_control fields
    localparam int unsigned CTL_INVERT_BIT = 0;
    localparam int unsigned CTL_EN_LSB     = 1;
    localparam int unsigned CTL_EN_MSB     = 15;

    // general_event_status fields
    localparam int unsigned STS_LSB        = 1;
    localparam int unsigned STS_MSB        = 15;

    // pin control register fields
    localparam int unsigned PIN_ALT_BIT    = 0;
    localparam int unsigned PIN_DIR_BIT    = 1;
    localparam int unsigned PIN_DATA_BIT   = 2;
    localparam int unsigned PIN_IN_BIT     = 3;
    localparam int unsigned PIN_EVENT_BIT  = 4;

    // the event is an alternate function of this general purpose pin
    localparam int unsigned EVENT_PIN_NUM  = 5;

    // reset values
    localparam logic [31:0] CONTROL_RESET  = 32'h0000_0000;
    localparam logic [31:0] STATUS_RESET   = 32'h0000_0000;
    localparam logic        INVERT_RESET   = 1'h0;
    localparam logic        ALT_RESET      = 1'h0;
    localparam logic        DIR_RESET      = 1'h0;
    localparam logic        DATA_RESET     = 1'h0;
    localparam logic [31:0] READ_ZERO      = 32'h0000_0000;

    // synchroniser depth for pin inputs
    localparam int unsigned SYNC_STAGES    = 3;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    typedef struct packed {
        logic [15:1] intx;
        logic [15:1] msi;
        logic [15:1] pme;
    } notify_t;

    typedef struct packed {
        logic        alt;
        logic        dir;
        logic        data;
    } pin_cfg_t;

endpackage

// File: rtl/pin_sync.sv
// three stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module pin_sync
    import gpe_pkg::*;
#(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] stable
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_stable;

    // a change counts only once the second and third stages agree
    always_comb begin
        next_stable = stable;
        for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
                next_stable[i] = stage3[i];
            end
        end
    end

    // stage1 feeds stage2 only, never any other logic
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            stable <= '0;
        end else begin
            stage1 <= raw;
            stage2 <= stage1;
            stage3 <= stage2;
            stable <= next_stable;
        end
    end

endmodule

// File: rtl/general_event_status.sv
// general purpose event status, control and shared event pin logic
//
// What this block does
// - read-only status, ports 1-15, resets zero
// - status bit set one cycle after an enabled port signals, held while it does
// - status never set while port disabled
// - event output carried on general pin five
// - pin carries event only in alternate function
// - pin active low; invert bit makes pin active high
// - enabled port suppresses legacy notifications
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module general_event_status
    import gpe_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire bus_req_t    bus_req,
    output logic      [31:0] rdata,
    input  wire notify_t     notify_req,
    output notify_t          notify_out,
    input  wire logic        gpio5_in,
    output logic             gpio5_out,
    output logic             gpio5_oe_n,
    output logic             shared_event_output
);

    // decode used by both write and read paths
    function automatic logic hit(input logic [11:0] addr, input logic [11:0] offset);
        return addr == offset;
    endfunction

    // pin level for an event state under the chosen polarity
    function automatic logic event_level(input logic active, input logic invert);
        return invert ? active : ~active;
    endfunction

    // control register state
    logic [15:1] port_event_redirect_enable;
    logic        event_polarity_invert;
    logic [15:1] next_redirect_enable;
    logic        next_polarity_invert;

    // pin configuration state
    pin_cfg_t    pin_cfg;
    pin_cfg_t    next_pin_cfg;

    // status and outputs
    logic [15:1] general_event_status_q;
    logic [15:1] next_status;
    logic [15:1] port_event_pending;
    logic        next_event;
    logic        next_gpio5_out;
    logic        next_gpio5_oe_n;
    notify_t     next_notify;
    logic [31:0] next_rdata;
    logic        pin_in_stable;

    logic        wr_control;
    logic        wr_pin;

    assign wr_control = bus_req.wr && hit(bus_req.addr, CONTROL_OFFSET);
    assign wr_pin     = bus_req.wr && hit(bus_req.addr, PIN_OFFSET);

    pin_sync #(
        .WIDTH (1)
    ) u_pin_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .raw     (gpio5_in),
        .stable  (pin_in_stable)
    );

    // control register: per-port redirect enables and polarity
    always_comb begin
        next_redirect_enable = port_event_redirect_enable;
        next_polarity_invert = event_polarity_invert;
        if (wr_control) begin
            next_redirect_enable = bus_req.wdata[CTL_EN_MSB:CTL_EN_LSB];
            next_polarity_invert = bus_req.wdata[CTL_INVERT_BIT];
        end
    end

    // sticky in the device; here sys_rst stands for the fundamental reset
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            port_event_redirect_enable <= CONTROL_RESET[CTL_EN_MSB:CTL_EN_LSB];
            event_polarity_invert      <= INVERT_RESET;
        end else begin
            port_event_redirect_enable <= next_redirect_enable;
            event_polarity_invert      <= next_polarity_invert;
        end
    end

    // pin configuration: alternate function select, direction, data
    always_comb begin
        next_pin_cfg = pin_cfg;
        if (wr_pin) begin
            next_pin_cfg.alt  = bus_req.wdata[PIN_ALT_BIT];
            next_pin_cfg.dir  = bus_req.wdata[PIN_DIR_BIT];
            next_pin_cfg.data = bus_req.wdata[PIN_DATA_BIT];
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pin_cfg.alt  <= ALT_RESET;
            pin_cfg.dir  <= DIR_RESET;
            pin_cfg.data <= DATA_RESET;
        end else begin
            pin_cfg <= next_pin_cfg;
        end
    end

    // per-port event routing
    genvar p;
    generate
        for (p = 1; p <= NUM_PORTS; p++) begin : g_port
            // any hot-plug notification the port wants to raise
            assign port_event_pending[p] = notify_req.intx[p] | notify_req.msi[p] | notify_req.pme[p];

            // status follows the pending event, gated by the enable
            assign next_status[p] = port_event_redirect_enable[p] & port_event_pending[p];

            // redirected ports lose their legacy notifications
            assign next_notify.intx[p] = notify_req.intx[p] & ~port_event_redirect_enable[p];
            assign next_notify.msi[p]  = notify_req.msi[p]  & ~port_event_redirect_enable[p];
            assign next_notify.pme[p]  = notify_req.pme[p]  & ~port_event_redirect_enable[p];
        end
    endgenerate

    // the shared event is the or of all status bits
    assign next_event = |next_status;

    // pin drive: event only in alternate function, always driven there; else data bit, driven only while dir is set
    always_comb begin
        next_gpio5_out  = pin_cfg.data;
        next_gpio5_oe_n = ~pin_cfg.dir;
        if (pin_cfg.alt) begin
            next_gpio5_out  = event_level(next_event, event_polarity_invert);
            next_gpio5_oe_n = 1'h0;
        end
    end

    // status, pin and notify registered together so they stay aligned
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            general_event_status_q <= STATUS_RESET[STS_MSB:STS_LSB];
            shared_event_output    <= 1'h0;
            // idle level of an active-low pin is high
            gpio5_out              <= 1'h1;
            gpio5_oe_n             <= 1'h1;
            notify_out             <= '0;
        end else begin
            general_event_status_q <= next_status;
            shared_event_output    <= next_event;
            gpio5_out              <= next_gpio5_out;
            gpio5_oe_n             <= next_gpio5_oe_n;
            notify_out             <= next_notify;
        end
    end

    // read path: data in the cycle after the strobe, zero otherwise
    always_comb begin
        next_rdata = READ_ZERO;
        if (bus_req.rd) begin
            if (hit(bus_req.addr, CONTROL_OFFSET)) begin
                next_rdata[CTL_EN_MSB:CTL_EN_LSB] = port_event_redirect_enable;
                next_rdata[CTL_INVERT_BIT]        = event_polarity_invert;
            end else if (hit(bus_req.addr, STATUS_OFFSET)) begin
                // writes to this offset are simply not decoded
                next_rdata[STS_MSB:STS_LSB] = general_event_status_q;
            end else if (hit(bus_req.addr, PIN_OFFSET)) begin
                next_rdata[PIN_ALT_BIT]   = pin_cfg.alt;
                next_rdata[PIN_DIR_BIT]   = pin_cfg.dir;
                next_rdata[PIN_DATA_BIT]  = pin_cfg.data;
                next_rdata[PIN_IN_BIT]    = pin_in_stable;
                next_rdata[PIN_EVENT_BIT] = shared_event_output;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rdata <= READ_ZERO;
        end else begin
            rdata <= next_rdata;
        end
    end

endmodule

// File: dv/general_event_status_asserts.sv
// checker for the general purpose event status block
`timescale 1ns/1ps
module general_event_status_asserts
    import gpe_pkg::*;
(
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire bus_req_t    bus_req,
    input wire logic [31:0] rdata,
    input wire notify_t     notify_req,
    input wire notify_t     notify_out,
    input wire logic        gpio5_in,
    input wire logic        gpio5_out,
    input wire logic        gpio5_oe_n,
    input wire logic        shared_event_output
);
    logic [15:0] ctl;
    logic [2:0]  pin;
    logic [15:1] ev;
    notify_t     fwd;
    // shadow copies, the checker sees only the bus
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctl <= 16'h0000;
            pin <= 3'h0;
        end else if (bus_req.wr && bus_req.addr == CONTROL_OFFSET) begin
            ctl <= bus_req.wdata[15:0];
        end else if (bus_req.wr && bus_req.addr == PIN_OFFSET) begin
            pin <= bus_req.wdata[2:0];
        end
    end
    assign ev = ctl[15:1] & (notify_req.intx | notify_req.msi | notify_req.pme);
    assign fwd = notify_req & {~ctl[15:1], ~ctl[15:1], ~ctl[15:1]};
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_status_rd;
        bus_req.rd && bus_req.addr == STATUS_OFFSET;
    endsequence
    sequence s_unmapped_rd;
        bus_req.rd && bus_req.addr != CONTROL_OFFSET && bus_req.addr != STATUS_OFFSET && bus_req.addr != PIN_OFFSET;
    endsequence
    a_event_any_port: assert property (shared_event_output == ($past(ev) != 15'h0000))
        else $error("event output wrong");
    a_notify_redirect: assert property (notify_out == $past(fwd))
        else $error("notify passthrough wrong");
    a_alt_drives_pin: assert property ($past(pin[0]) |-> !gpio5_oe_n)
        else $error("alt pin not driven");
    a_pin_polarity: assert property ($past(pin[0]) |-> gpio5_out == ($past(ctl[0]) ~^ shared_event_output))
        else $error("pin polarity wrong");
    a_plain_gpio: assert property (!$past(pin[0]) |-> gpio5_oe_n == !$past(pin[1]))
        else $error("plain pin mode wrong");
    a_status_read: assert property (s_status_rd |=> rdata[0] == 1'b0 && rdata[31:16] == 16'h0000
        && (rdata != 32'h0) == $past(shared_event_output))
        else $error("status read wrong");
    a_status_bits: assert property (s_status_rd |=> rdata[15:1] == $past(ev, 2))
        else $error("status bits wrong");
    a_unmapped_zero: assert property (s_unmapped_rd |=> rdata == READ_ZERO)
        else $error("unmapped read not zero");
    a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == READ_ZERO)
        else $error("rdata not idle");
endmodule
bind general_event_status general_event_status_asserts u_asserts (.clock(clock), .sys_rst(sys_rst),
    .bus_req(bus_req), .rdata(rdata), .notify_req(notify_req), .notify_out(notify_out), .gpio5_in(gpio5_in),
    .gpio5_out(gpio5_out), .gpio5_oe_n(gpio5_oe_n), .shared_event_output(shared_event_output));

// File: dv/event_pin_monitor.sv
// management logic sensing the shared event pin
`timescale 1ns/1ps
module event_pin_monitor (
    input  wire logic gpio5_out,
    input  wire logic gpio5_oe_n,
    input  wire logic invert,
    output logic      pin_level,
    output logic      event_seen
);
    // board pull-up, so an undriven pin reads high
    assign pin_level  = gpio5_oe_n ? 1'b1 : gpio5_out;
    assign event_seen = invert ? pin_level : !pin_level;
endmodule

// File: dv/general_event_status_tb_top.sv
// testbench for the general purpose event status block
`timescale 1ns/1ps
module general_event_status_tb_top
    import gpe_pkg::*;
;
    logic        clock;
    logic        sys_rst;
    bus_req_t    bus_req;
    logic [31:0] rdata;
    notify_t     notify_req;
    notify_t     notify_out;
    notify_t     kind;
    logic        gpio5_out;
    logic        gpio5_oe_n;
    logic        shared_event_output;
    logic        pin_level;
    logic        event_seen;
    logic        invert;
    logic [15:1] en;
    int          miscompares;
    int          checks;
    general_event_status u_dut (.clock(clock), .sys_rst(sys_rst), .bus_req(bus_req), .rdata(rdata),
        .notify_req(notify_req), .notify_out(notify_out), .gpio5_in(pin_level), .gpio5_out(gpio5_out),
        .gpio5_oe_n(gpio5_oe_n), .shared_event_output(shared_event_output));
    event_pin_monitor u_monitor (.gpio5_out(gpio5_out), .gpio5_oe_n(gpio5_oe_n), .invert(invert),
        .pin_level(pin_level), .event_seen(event_seen));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [44:0] exp, input logic [44:0] seen);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] addr, input logic [31:0] data);
        @(posedge clock);
        bus_req.addr  <= addr;
        bus_req.wdata <= data;
        bus_req.wr    <= 1'b1;
        @(posedge clock);
        bus_req.wr    <= 1'b0;
    endtask
    // rdata stands one cycle only; taken at the edge that closes that cycle
    task automatic rd(input logic [11:0] addr, input logic [31:0] exp);
        @(posedge clock);
        bus_req.addr <= addr;
        bus_req.rd   <= 1'b1;
        @(posedge clock);
        bus_req.rd   <= 1'b0;
        @(posedge clock);
        chk("rdata", {13'h0000, exp}, {13'h0000, rdata});
    endtask
    initial begin
        sys_rst     = 1'b1;
        bus_req     = '0;
        notify_req  = '0;
        invert      = 1'b0;
        miscompares = 0;
        checks      = 0;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        rd(STATUS_OFFSET, STATUS_RESET);
        rd(12'h000, READ_ZERO);
        notify_req <= '1;
        wr(STATUS_OFFSET, 32'hffff_ffff);
        rd(STATUS_OFFSET, STATUS_RESET);
        chk("notify_out", {45{1'b1}}, notify_out);
        chk("event", 45'h0, {44'h0, shared_event_output});
        // one port at a time, cycling through the three notification kinds
        for (int p = 1; p <= 15; p++) begin
            en = '0;
            en[p] = 1'b1;
            kind = {{15{p % 3 == 0}}, {15{p % 3 == 1}}, {15{p % 3 == 2}}};
            notify_req <= kind;
            wr(CONTROL_OFFSET, {16'h0000, en, 1'b0});
            rd(STATUS_OFFSET, {16'h0000, en, 1'b0});
            chk("notify_out", kind & {~en, ~en, ~en}, notify_out);
            chk("event", 45'h1, {44'h0, shared_event_output});
        end
        wr(PIN_OFFSET, 32'h0000_0001);
        repeat (2) @(posedge clock);
        chk("pin", 45'h0, {44'h0, pin_level});
        chk("seen", 45'h1, {44'h0, event_seen});
        invert <= 1'b1;
        wr(CONTROL_OFFSET, 32'h0000_8001);
        rd(CONTROL_OFFSET, 32'h0000_8001);
        chk("pin", 45'h1, {44'h0, pin_level});
        chk("seen", 45'h1, {44'h0, event_seen});
        notify_req <= '0;
        repeat (2) @(posedge clock);
        chk("seen", 45'h0, {44'h0, event_seen});
        chk("event", 45'h0, {44'h0, shared_event_output});
        rd(STATUS_OFFSET, STATUS_RESET);
        notify_req <= '1;
        wr(PIN_OFFSET, 32'h0000_0000);
        repeat (5) @(posedge clock);
        chk("oe_n", 45'h1, {44'h0, gpio5_oe_n});
        rd(PIN_OFFSET, 32'h0000_0018);
        // plain output mode: driven, data bit on the pin
        wr(PIN_OFFSET, 32'h0000_0006);
        rd(PIN_OFFSET, 32'h0000_001e);
        chk("oe_n", 45'h0, {44'h0, gpio5_oe_n});
        chk("out", 45'h1, {44'h0, gpio5_out});
        finish_test();
    end
    initial begin
        repeat (2000) @(posedge clock);
        miscompares++;
        finish_test();
    end
endmodule
